/* src/port_pkg.sv */
// Constants for the four-bit port with shared reset pin input
// Operation
// - Large package: four bits, three bidirectional
// - Analog-selected pin reads zero
// - Direction one floats, zero drives latch
// - Direction still controls driver in analog
// - Power-on: three pins select analog
// - Latch register readable, holds latched values
// - Config zero: digital input; one: master clear
// - Fourth pin always input, no direction
// - Fourth pin digital only if clear disabled
// - Small package: only fourth-pin bit exists
// - Bits 7-4 zero; bit 3 gated
// - Small package: other bits read zero
// - Output latch drives regardless of analog
// - Latch, direction implement bits 2-0 only
package port_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W            = 4;
  localparam int          DATA_W            = 8;
  localparam int          IO_PINS           = 3;
  localparam logic [3:0]  ADDR_PIN_DATA     = 4'h0;
  localparam logic [3:0]  ADDR_OUT_LATCH    = 4'h1;
  localparam logic [3:0]  ADDR_DIRECTION    = 4'h2;
  localparam logic [3:0]  ADDR_ANALOG_SEL   = 4'h3;
  localparam logic [3:0]  ADDR_PORT_STATUS  = 4'h4;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          INPUT_ONLY_BIT    = 3;
  localparam logic [2:0]  LATCH_RST         = 3'h0;
  localparam logic [2:0]  DIR_RST           = 3'h7;
  localparam logic [2:0]  ANALOG_RST        = 3'h7;
  localparam logic [7:0]  READ_ZERO         = 8'h00;

endpackage

/* src/pin_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Two stages; first read only by second
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

/* src/port_pad.sv */
// Pad control for one bidirectional port pin
`timescale 1ns/1ps
module port_pad (
  input  wire logic latch_i,
  input  wire logic dir_in_i,
  input  wire logic analog_i,
  input  wire logic pin_sync_i,
  output logic      pad_out_o,
  output logic      pad_oe_n_o,
  output logic      read_o
);
  // Driver follows direction only, analog ignored
  assign pad_out_o  = latch_i;
  assign pad_oe_n_o = dir_in_i;
  // Digital input path cut while analog selected
  assign read_o     = analog_i ? 1'b0 : pin_sync_i;
endmodule

/* src/port_top.sv */
// Four-bit port with three I/O pins and shared reset pin input
`timescale 1ns/1ps
module port_top
  import port_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  input  wire logic [port_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [port_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [port_pkg::DATA_W-1:0]  rdata_o,
  input  wire logic                         reset_pin_enable_cfg_i,
  input  wire logic [port_pkg::IO_PINS-1:0] io_pin_in_i,
  output logic      [port_pkg::IO_PINS-1:0] io_pin_out_o,
  output logic      [port_pkg::IO_PINS-1:0] io_pin_oe_n_o,
  input  wire logic                         input_only_pin_i,
  output logic                              master_clear_input_o,
  output logic                              analog_channel_a_o,
  output logic                              analog_channel_b_o,
  output logic                              analog_channel_c_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [IO_PINS-1:0] latch_q;
  logic [IO_PINS-1:0] dir_q;
  logic [IO_PINS-1:0] analog_q;
  logic [DATA_W-1:0]  rdata_q;
  logic [IO_PINS:0]   pins_sync;
  logic [IO_PINS-1:0] pin_read;
  logic [IO_PINS-1:0] pad_out;
  logic [IO_PINS-1:0] pad_oe_n;
  logic               rst_pin_en;
  logic               io_ok;
  logic               bit3_read;
  logic               wr_data;
  logic               wr_latch;
  logic               wr_dir;
  logic               wr_analog;
  logic [DATA_W-1:0]  rd_mux;

  // ---------------------------------------------------------------
  // Pin input synchronisation
  // ---------------------------------------------------------------
  pin_sync #(
    .WIDTH (IO_PINS + 1)
  ) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i ({input_only_pin_i, io_pin_in_i}),
    .sync_o  (pins_sync)
  );

  // Per-pin pad logic
  for (genvar g = 0; g < IO_PINS; g++)
  begin : g_pad
    port_pad u_pad (
      .latch_i    (latch_q[g]),
      .dir_in_i   (dir_q[g]),
      .analog_i   (analog_q[g]),
      .pin_sync_i (pins_sync[g]),
      .pad_out_o  (pad_out[g]),
      .pad_oe_n_o (pad_oe_n[g]),
      .read_o     (pin_read[g])
    );
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Config bit is static; kept as-is
  assign rst_pin_en = reset_pin_enable_cfg_i;
  assign io_ok      = LARGE_PKG;
  assign wr_data    = wr_i && (addr_i == ADDR_PIN_DATA);
  assign wr_latch   = wr_i && (addr_i == ADDR_OUT_LATCH);
  assign wr_dir     = wr_i && (addr_i == ADDR_DIRECTION);
  assign wr_analog  = wr_i && (addr_i == ADDR_ANALOG_SEL);
  // Fourth pin: digital only when clear disabled
  assign bit3_read  = rst_pin_en ? 1'b0 : pins_sync[INPUT_ONLY_BIT];

  // Register latch; data and latch writes both load it
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      latch_q <= LATCH_RST;
    else if (io_ok && (wr_data || wr_latch))
      latch_q <= wdata_i[IO_PINS-1:0];
  end

  // Direction, power-on all inputs
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      dir_q <= DIR_RST;
    else if (io_ok && wr_dir)
      dir_q <= wdata_i[IO_PINS-1:0];
  end

  // Analog select, power-on all analog
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      analog_q <= ANALOG_RST;
    else if (io_ok && wr_analog)
      analog_q <= wdata_i[IO_PINS-1:0];
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_mux = READ_ZERO;
    case (addr_i)
      ADDR_PIN_DATA:
      begin
        rd_mux[INPUT_ONLY_BIT] = bit3_read;
        if (io_ok)
          rd_mux[IO_PINS-1:0] = pin_read;
      end
      ADDR_OUT_LATCH:
        if (io_ok)
          rd_mux[IO_PINS-1:0] = latch_q;
      ADDR_DIRECTION:
        if (io_ok)
          rd_mux[IO_PINS-1:0] = dir_q;
      ADDR_ANALOG_SEL:
        if (io_ok)
          rd_mux[IO_PINS-1:0] = analog_q;
      ADDR_PORT_STATUS:
      begin
        rd_mux[0] = rst_pin_en;
        rd_mux[1] = io_ok;
      end
      default:
        rd_mux = READ_ZERO;
    endcase
  end

  // Read data stands the cycle after the strobe only
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      rdata_q <= READ_ZERO;
    else if (rd_i)
      rdata_q <= rd_mux;
    else
      rdata_q <= READ_ZERO;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata_o              = rdata_q;
  assign io_pin_out_o         = io_ok ? pad_out : LATCH_RST;
  assign io_pin_oe_n_o        = io_ok ? pad_oe_n : DIR_RST;
  // Fourth pin never driven; feeds reset when enabled
  assign master_clear_input_o = rst_pin_en & pins_sync[INPUT_ONLY_BIT];
  assign analog_channel_a_o   = analog_q[0];
  assign analog_channel_b_o   = analog_q[1];
  assign analog_channel_c_o   = analog_q[2];
endmodule

/* test/port_top_monitor.sv */
// Checker of the port register and pin relations
`timescale 1ns/1ps
module port_top_monitor
  import port_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1
) (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       reset_pin_enable_cfg_i,
  input wire logic [2:0] io_pin_in_i,
  input wire logic [2:0] io_pin_out_o,
  input wire logic [2:0] io_pin_oe_n_o,
  input wire logic       input_only_pin_i,
  input wire logic       master_clear_input_o,
  input wire logic       analog_channel_a_o,
  input wire logic       analog_channel_b_o,
  input wire logic       analog_channel_c_o
);
  wire [2:0] ana = {analog_channel_c_o, analog_channel_b_o, analog_channel_a_o};
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // Write cycles
  // ----------------------------------------
  sequence latch_wr_s;
    LARGE_PKG && wr_i && (addr_i == ADDR_OUT_LATCH || addr_i == ADDR_PIN_DATA);
  endsequence
  sequence dir_wr_s;
    LARGE_PKG && wr_i && addr_i == ADDR_DIRECTION;
  endsequence
  // Outputs against their causes
  latch_drive_a: assert property (latch_wr_s |=> io_pin_out_o == $past(wdata_i[2:0]))
    else $error("latch not driven");
  dir_write_a: assert property (dir_wr_s |=> io_pin_oe_n_o == $past(wdata_i[2:0]))
    else $error("direction not applied");
  dir_hold_a: assert property (!(wr_i && addr_i == ADDR_DIRECTION) |=> $stable(io_pin_oe_n_o))
    else $error("direction changed");
  upper_zero_a: assert property (rdata_o[7:4] == 4'h0)
    else $error("upper bits set");
  idle_zero_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data without read");
  clear_gate_a: assert property (rd_i && reset_pin_enable_cfg_i |=> !rdata_o[3])
    else $error("bit 3 not gated");
  analog_mask_a: assert property (rd_i && addr_i == ADDR_PIN_DATA |=> (rdata_o[2:0] & $past(ana)) == 3'h0)
    else $error("analog pin read high");
  clear_off_a: assert property (!reset_pin_enable_cfg_i [*2] |-> !master_clear_input_o)
    else $error("master clear while disabled");
  small_quiet_a: assert property (!LARGE_PKG |-> io_pin_oe_n_o == 3'h7)
    else $error("small package pin driven");
endmodule
bind port_top port_top_monitor #(.LARGE_PKG(LARGE_PKG)) i_port_top_monitor (.*);

/* test/pin_model.sv */
// Pads with an outside driver behind them
`timescale 1ns/1ps
module pin_model (
  input  wire logic       clock_i,
  input  wire logic [2:0] out_i,
  input  wire logic [2:0] oe_n_i,
  input  wire logic [2:0] ext_i,
  input  wire logic [2:0] ext_en_i,
  output logic      [2:0] level_o
);
  logic [2:0] float_q = 3'h0;
  // Undriven pins wander
  always @(posedge clock_i) float_q <= ~float_q;
  // Device driver first, then outside source
  assign level_o = (~oe_n_i & out_i) | (oe_n_i & ext_en_i & ext_i)
                 | (oe_n_i & ~ext_en_i & float_q);
endmodule

/* test/test_port_top.sv */
// Self-checking bench of the four-bit port
`timescale 1ns/1ps
module test_port_top;
  import port_pkg::*;
  logic       clock_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, cfg = 0, only = 1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [2:0] ext = 3'h0, ext_en = 3'h0;
  wire  [7:0] rdata_o;
  wire  [2:0] pin, pout, poe_n;
  wire        master_clear_input, a_a, a_b, a_c;
  wire  [7:0] rdata_s;
  wire  [2:0] pout_s, poe_s;
  wire        master_clear_input_s, s_a, s_b, s_c;
  int         mismatches = 0, tests_run = 0;
  always #2.5 clock_i = ~clock_i;
  port_top i_port_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .reset_pin_enable_cfg_i(cfg), .io_pin_in_i(pin), .io_pin_out_o(pout),
    .io_pin_oe_n_o(poe_n), .input_only_pin_i(only), .master_clear_input_o(master_clear_input),
    .analog_channel_a_o(a_a), .analog_channel_b_o(a_b), .analog_channel_c_o(a_c));
  pin_model i_pin_model (.clock_i(clock_i), .out_i(pout), .oe_n_i(poe_n),
    .ext_i(ext), .ext_en_i(ext_en), .level_o(pin));
  // Small package variant on the same bus
  port_top #(.LARGE_PKG(1'b0)) i_port_top_small (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_s),
    .reset_pin_enable_cfg_i(cfg), .io_pin_in_i(pin), .io_pin_out_o(pout_s),
    .io_pin_oe_n_o(poe_s), .input_only_pin_i(only), .master_clear_input_o(master_clear_input_s),
    .analog_channel_a_o(s_a), .analog_channel_b_o(s_b), .analog_channel_c_o(s_c));
  // Compare and count
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 cmp("rdata", exp, rdata_o);
  endtask
  task automatic rd_small(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 cmp("small rdata", exp, rdata_s);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_state;
    rd(ADDR_DIRECTION, 8'h07);
    rd(ADDR_ANALOG_SEL, 8'h07);
    rd(ADDR_OUT_LATCH, 8'h00);
    rd(ADDR_PIN_DATA, 8'h08);
    cmp("oe_n", {5'h00, poe_n}, 8'h07);
    cmp("ana", {5'h00, a_c, a_b, a_a}, 8'h07);
  endtask
  task automatic drive_latch;
    wr(ADDR_OUT_LATCH, 8'hfa);
    rd(ADDR_OUT_LATCH, 8'h02);
    wr(ADDR_DIRECTION, 8'hf8);
    rd(ADDR_DIRECTION, 8'h00);
    cmp("pins", {5'h00, pin}, 8'h02);
    wr(ADDR_PIN_DATA, 8'h05);
    #1 cmp("pout", {5'h00, pout}, 8'h05);
    rd(ADDR_PIN_DATA, 8'h08);
  endtask
  task automatic digital_in;
    wr(ADDR_DIRECTION, 8'h07);
    ext <= 3'h2;
    ext_en <= 3'h7;
    wr(ADDR_ANALOG_SEL, 8'h00);
    repeat (3) @(posedge clock_i);
    rd(ADDR_PIN_DATA, 8'h0a);
    rd(ADDR_OUT_LATCH, 8'h05);
    cfg <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd(ADDR_PIN_DATA, 8'h02);
    cmp("master_clear_input", {7'h00, master_clear_input}, 8'h01);
    rd(4'hf, 8'h00);
    wr(ADDR_ANALOG_SEL, 8'h05);
    rd(ADDR_PIN_DATA, 8'h02);
  endtask
  task automatic small_pkg;
    wr(ADDR_OUT_LATCH, 8'hff);
    wr(ADDR_DIRECTION, 8'h00);
    rd_small(ADDR_OUT_LATCH, 8'h00);
    rd_small(ADDR_DIRECTION, 8'h00);
    rd_small(ADDR_PIN_DATA, 8'h00);
    cmp("small oe_n", {5'h00, poe_s}, 8'h07);
    cmp("small pout", {5'h00, pout_s}, 8'h00);
    cmp("small master_clear_input", {7'h00, master_clear_input_s}, 8'h01);
    cfg <= 1'b0;
    repeat (3) @(posedge clock_i);
    rd_small(ADDR_PIN_DATA, 8'h08);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    reset_state;
    drive_latch;
    digital_in;
    small_pkg;
    summarize;
  end
  initial
  begin
    #100000;
    mismatches++;
    summarize;
  end
endmodule
